/* File: rtl/wake_timer_consts.svh */
/*
 * Constants for the wake-on-radio timer control: register address,
 * reset and mask values, slow clock divider, settle and scale tables.
 * Assumes inclusion by its bare name from the divider and timer control files.
 */
`ifndef WAKE_TIMER_CONSTS_SVH
`define WAKE_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define WT_CTRL_ADDR      6'h20
`define WT_CTRL_RESET     8'hF8
`define WT_CTRL_WMASK     8'hFB
`define WT_RDATA_NONE     8'h00

// ----------------------------------------------------------------
// Slow clock: crystal clock divided by 750
// ----------------------------------------------------------------
`define WT_SLOW_DIV_LAST  10'h2ED
`define WT_DIV_ZERO       10'h000
`define WT_DIV_ONE        10'h001

// ----------------------------------------------------------------
// Settle interval, in slow periods, per code
// ----------------------------------------------------------------
`define WT_SETTLE_C0      6'h04
`define WT_SETTLE_C1      6'h06
`define WT_SETTLE_C2      6'h08
`define WT_SETTLE_C3      6'h0C
`define WT_SETTLE_C4      6'h10
`define WT_SETTLE_C5      6'h18
`define WT_SETTLE_C6      6'h20
`define WT_SETTLE_C7      6'h30
`define WT_SETTLE_ONE     6'h01
`define WT_SETTLE_ZERO    6'h00

// ----------------------------------------------------------------
// Tick scale: last prescaler value per code (scale minus one)
// ----------------------------------------------------------------
`define WT_SCALE_LAST_0   15'h0000
`define WT_SCALE_LAST_1   15'h001F
`define WT_SCALE_LAST_2   15'h03FF
`define WT_SCALE_LAST_3   15'h7FFF
`define WT_PRE_ONE        15'h0001

// ----------------------------------------------------------------
// Period counter and calibration length
// ----------------------------------------------------------------
`define WT_PERIOD_ZERO    16'h0000
`define WT_PERIOD_ONE     16'h0001
`define WT_CAL_LAST       3'h3
`define WT_CAL_ONE        3'h1
`define WT_CAL_ZERO       3'h0

`endif

/* File: rtl/wake_timer_pkg.sv */
/*
 * Types for the wake-on-radio timer control: control register layout,
 * register access request and the oscillator state machine.
 * Assumes the constants header is compiled alongside.
 */
package wake_timer_pkg;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       slow_osc_powerdown;     // 1 = slow oscillator off
        logic [2:0] settle_interval_select; // Settle_interval_select delay code
        logic       slow_osc_cal_enable;    // Recalibration on/off
        logic       reserved;               // Reads zero
        logic [1:0] wake_tick_scale;        // Wake_period_count resolution code
    } wake_timer_control_t;

    // One register access from the serial register port
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle
        logic       rd;    // Read strobe, one cycle
        logic [5:0] addr;  // Register address
        logic [7:0] wdata; // Write data
    } reg_req_t;

    // Slow oscillator state
    typedef enum logic [1:0] {
        OSC_OFF = 2'b00,
        OSC_CAL = 2'b01,
        OSC_RUN = 2'b10
    } osc_state_t;

endpackage

/* File: rtl/slow_clock_divider.sv */
/*
 * Slow clock tick generator: one-cycle tick every 750 crystal cycles
 * while the slow oscillator runs.
 * Assumes clk is the crystal-derived clock and run is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_consts.svh"

module slow_clock_divider (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic run,
    output var  logic tick
);

    logic [9:0] div_ff;      // Crystal cycle counter
    logic [9:0] nxt_div;
    logic       tick_ff;     // Registered tick
    logic       div_wrap;
    logic [9:0] gap_ff;      // Checker: cycles since last tick
    logic       had_tick_ff; // Checker: a tick seen since run rose

    // ----------------------------------------------------------------
    // Divide by 750
    // ----------------------------------------------------------------
    assign div_wrap = run && (div_ff == `WT_SLOW_DIV_LAST);
    assign nxt_div  = !run ? `WT_DIV_ZERO : (div_wrap ? `WT_DIV_ZERO : div_ff + `WT_DIV_ONE);
    assign tick     = tick_ff;

    // Counter and tick register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff  <= `WT_DIV_ZERO;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= div_wrap;
        end
    end

    // Checker helpers, restarted by a tick or a stop; the first tick after
    // a start is not timed because the divider begins from a cleared count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_ff      <= `WT_DIV_ZERO;
            had_tick_ff <= 1'b0;
        end else begin
            gap_ff      <= (tick_ff || !run) ? `WT_DIV_ZERO : gap_ff + `WT_DIV_ONE;
            had_tick_ff <= run && (tick_ff || had_tick_ff);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_tick_spacing;
        @(posedge clk) disable iff (!reset_n)
        (run && had_tick_ff) |-> (tick_ff == (gap_ff == `WT_SLOW_DIV_LAST));
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("slow tick spacing not 750");

endmodule

`default_nettype wire

/* File: rtl/wake_on_radio_timer_control.sv */
/*
 * Wake-on-radio timer control: control register, slow oscillator
 * power-up and calibration, Wake_period_count period timer and Settle_interval_select delay.
 * Assumes register accesses arrive decoded from the serial port as
 * one-cycle strobes, and the 16-bit wake period count comes from the
 * neighbouring timeout registers.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wake_timer_consts.svh"

module wake_on_radio_timer_control (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire wake_timer_pkg::reg_req_t  reg_req,
    input  wire logic [15:0]               wake_period_count,
    output var  logic [7:0]                reg_rdata,
    output var  logic                      slow_osc_enable,
    output var  logic                      slow_osc_cal_active,
    output var  logic                      wake_period_count_pulse,
    output var  logic                      settle_interval_select_pulse
);

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    // Settle interval code to slow periods
    function automatic logic [5:0] settle_periods(input logic [2:0] code);
        logic [5:0] p;
        p = `WT_SETTLE_C0;
        case (code)
            3'h0: p = `WT_SETTLE_C0;
            3'h1: p = `WT_SETTLE_C1;
            3'h2: p = `WT_SETTLE_C2;
            3'h3: p = `WT_SETTLE_C3;
            3'h4: p = `WT_SETTLE_C4;
            3'h5: p = `WT_SETTLE_C5;
            3'h6: p = `WT_SETTLE_C6;
            default: p = `WT_SETTLE_C7;
        endcase
        return p;
    endfunction

    // Tick scale code to last prescaler value
    function automatic logic [14:0] scale_last(input logic [1:0] code);
        logic [14:0] s;
        s = `WT_SCALE_LAST_0;
        case (code)
            2'h0: s = `WT_SCALE_LAST_0;
            2'h1: s = `WT_SCALE_LAST_1;
            2'h2: s = `WT_SCALE_LAST_2;
            default: s = `WT_SCALE_LAST_3;
        endcase
        return s;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wake_timer_pkg::wake_timer_control_t ctrl_ff;    // Control register
    wake_timer_pkg::osc_state_t          state_ff;   // Oscillator state
    wake_timer_pkg::osc_state_t          nxt_state;
    logic [14:0] pre_ff;          // Prescaler in slow ticks
    logic [15:0] ev0_cnt_ff;      // Wake_period_count count
    logic [5:0]  settle_cnt_ff;   // Settle_interval_select delay count
    logic        settle_act_ff;   // Settle_interval_select delay running
    logic [2:0]  cal_cnt_ff;      // Calibration length count
    logic        recal_ff;        // Periodic recalibration running
    logic [7:0]  rdata_ff;        // Read data
    logic        ev0_ff;          // Wake_period_count pulse
    logic        ev1_ff;          // Settle_interval_select pulse
    logic        osc_en_ff;       // Oscillator enable
    logic        cal_act_ff;      // Calibration active
    logic        tick;            // Slow clock tick
    logic        ctrl_wr;         // Write to control register
    logic        ctrl_rd;         // Read of control register
    wake_timer_pkg::wake_timer_control_t wr_ctrl; // Masked write data
    logic        start_osc;       // Powerdown cleared while off
    logic        stop_osc;        // Powerdown set
    logic        run_tick;        // Tick while timer runs
    logic        pre_wrap;        // Prescaler completes one count
    logic [15:0] period_eff;      // Period, zero treated as one
    logic        fire0;           // Wake_period_count this cycle
    logic        fire1;           // Settle_interval_select this cycle
    logic        cal_done;        // Calibration length reached
    logic        cal_busy;        // Any calibration running
    logic [14:0] nxt_pre;
    logic [15:0] nxt_ev0_cnt;
    logic [5:0]  nxt_settle_cnt;
    logic        nxt_settle_act;
    logic        nxt_recal;
    logic [2:0]  nxt_cal_cnt;
    logic [7:0]  nxt_rdata;

    // ----------------------------------------------------------------
    // Slow clock
    // ----------------------------------------------------------------
    slow_clock_divider u_div (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (osc_en_ff),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------
    assign ctrl_wr   = reg_req.wr && (reg_req.addr == `WT_CTRL_ADDR);
    assign ctrl_rd   = reg_req.rd && (reg_req.addr == `WT_CTRL_ADDR);
    assign wr_ctrl   = reg_req.wdata & `WT_CTRL_WMASK;   // Reserved bit held at zero
    // Unmapped reads answer zero rather than stale data
    assign nxt_rdata = ctrl_rd ? ctrl_ff : `WT_RDATA_NONE;

    // ----------------------------------------------------------------
    // Oscillator state machine
    // ----------------------------------------------------------------
    assign start_osc = ctrl_wr && !wr_ctrl.slow_osc_powerdown && (state_ff == wake_timer_pkg::OSC_OFF);
    assign stop_osc  = ctrl_wr && wr_ctrl.slow_osc_powerdown;
    assign cal_busy  = (state_ff == wake_timer_pkg::OSC_CAL) || recal_ff;
    assign cal_done  = cal_busy && tick && (cal_cnt_ff == `WT_CAL_LAST);

    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            wake_timer_pkg::OSC_OFF: begin
                if (start_osc) begin
                    nxt_state = wake_timer_pkg::OSC_CAL;
                end
            end
            wake_timer_pkg::OSC_CAL: begin
                if (stop_osc) begin
                    nxt_state = wake_timer_pkg::OSC_OFF;
                end else if (cal_done) begin
                    nxt_state = wake_timer_pkg::OSC_RUN;
                end
            end
            wake_timer_pkg::OSC_RUN: begin
                if (stop_osc) begin
                    nxt_state = wake_timer_pkg::OSC_OFF;
                end
            end
            default: begin
                nxt_state = wake_timer_pkg::OSC_OFF;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Event timers
    // ----------------------------------------------------------------
    // Timer counts only once calibrated; it reloads after each Wake_period_count
    assign run_tick   = tick && (state_ff == wake_timer_pkg::OSC_RUN) && !stop_osc;
    assign pre_wrap   = run_tick && (pre_ff >= scale_last(ctrl_ff.wake_tick_scale));
    assign period_eff = (wake_period_count == `WT_PERIOD_ZERO) ? `WT_PERIOD_ONE : wake_period_count;
    assign fire0      = pre_wrap && (ev0_cnt_ff >= period_eff - `WT_PERIOD_ONE);
    assign nxt_pre    = !run_tick ? ((state_ff == wake_timer_pkg::OSC_RUN) ? pre_ff : `WT_SCALE_LAST_0)
                      : (pre_wrap ? `WT_SCALE_LAST_0 : pre_ff + `WT_PRE_ONE);
    assign nxt_ev0_cnt = (state_ff != wake_timer_pkg::OSC_RUN) ? `WT_PERIOD_ZERO
                       : (fire0 ? `WT_PERIOD_ZERO : (pre_wrap ? ev0_cnt_ff + `WT_PERIOD_ONE : ev0_cnt_ff));

    // Settle_interval_select delay, counted in plain slow periods after Wake_period_count
    assign fire1          = run_tick && settle_act_ff && !fire0
                          && (settle_cnt_ff == settle_periods(ctrl_ff.settle_interval_select) - `WT_SETTLE_ONE);
    assign nxt_settle_act = (state_ff != wake_timer_pkg::OSC_RUN) ? 1'b0
                          : (fire0 ? 1'b1 : (fire1 ? 1'b0 : settle_act_ff));
    assign nxt_settle_cnt = (fire0 || !settle_act_ff) ? `WT_SETTLE_ZERO
                          : (run_tick ? settle_cnt_ff + `WT_SETTLE_ONE : settle_cnt_ff);

    // ----------------------------------------------------------------
    // Calibration
    // ----------------------------------------------------------------
    // Recalibration rides alongside the timer so Wake_period_count never slips
    assign nxt_recal   = (state_ff == wake_timer_pkg::OSC_RUN) && !stop_osc
                       && ((fire0 && ctrl_ff.slow_osc_cal_enable) || (recal_ff && !cal_done));
    assign nxt_cal_cnt = (!cal_busy || cal_done) ? `WT_CAL_ZERO
                       : (tick ? cal_cnt_ff + `WT_CAL_ONE : cal_cnt_ff);

    // Control register and read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff  <= `WT_CTRL_RESET;
            rdata_ff <= `WT_RDATA_NONE;
        end else begin
            ctrl_ff  <= ctrl_wr ? wr_ctrl : ctrl_ff;
            rdata_ff <= nxt_rdata;
        end
    end

    // State, counters and output pulses
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff      <= wake_timer_pkg::OSC_OFF;
            pre_ff        <= `WT_SCALE_LAST_0;
            ev0_cnt_ff    <= `WT_PERIOD_ZERO;
            settle_cnt_ff <= `WT_SETTLE_ZERO;
            settle_act_ff <= 1'b0;
            cal_cnt_ff    <= `WT_CAL_ZERO;
            recal_ff      <= 1'b0;
            ev0_ff        <= 1'b0;
            ev1_ff        <= 1'b0;
            osc_en_ff     <= 1'b0;
            cal_act_ff    <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            pre_ff        <= nxt_pre;
            ev0_cnt_ff    <= nxt_ev0_cnt;
            settle_cnt_ff <= nxt_settle_cnt;
            settle_act_ff <= nxt_settle_act;
            cal_cnt_ff    <= nxt_cal_cnt;
            recal_ff      <= nxt_recal;
            ev0_ff        <= fire0;
            ev1_ff        <= fire1;
            osc_en_ff     <= (nxt_state != wake_timer_pkg::OSC_OFF);
            cal_act_ff    <= (nxt_state == wake_timer_pkg::OSC_CAL) || nxt_recal;
        end
    end

    assign reg_rdata           = rdata_ff;
    assign slow_osc_enable     = osc_en_ff;
    assign slow_osc_cal_active = cal_act_ff;
    assign wake_period_count_pulse        = ev0_ff;
    assign settle_interval_select_pulse        = ev1_ff;

    // ----------------------------------------------------------------
    // Checker helpers
    // ----------------------------------------------------------------
    logic [31:0] since_ev0_ff;  // Slow ticks since last Wake_period_count
    logic        quiet_ff;      // Wake_period_count seen, control unchanged since
    logic        ev1_seen_ff;   // Settle_interval_select already given this cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_ev0_ff <= 32'h0000_0000;
            quiet_ff     <= 1'b0;
            ev1_seen_ff  <= 1'b0;
        end else begin
            since_ev0_ff <= fire0 ? 32'h0000_0000 : (run_tick ? since_ev0_ff + 32'h0000_0001 : since_ev0_ff);
            quiet_ff     <= (state_ff == wake_timer_pkg::OSC_RUN) && !ctrl_wr && (fire0 || quiet_ff);
            ev1_seen_ff  <= fire0 ? 1'b0 : (fire1 || ev1_seen_ff);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_powerup_write;
        (state_ff == wake_timer_pkg::OSC_OFF) && ctrl_wr && !wr_ctrl.slow_osc_powerdown;
    endsequence
    sequence s_osc_calibrating;
        slow_osc_enable && slow_osc_cal_active;
    endsequence

    property p_powerup_cal;
        @(posedge clk) disable iff (!reset_n)
        s_powerup_write |=> s_osc_calibrating;
    endproperty
    a_powerup_cal: assert property (p_powerup_cal) else $error("no calibration after powerup");

    property p_settle_delay;
        @(posedge clk) disable iff (!reset_n)
        (fire1 && quiet_ff) |->
            (since_ev0_ff == {26'h0, settle_periods(ctrl_ff.settle_interval_select)} - 32'h0000_0001);
    endproperty
    a_settle_delay: assert property (p_settle_delay) else $error("settle_interval_select delay wrong");

    property p_recal_needs_enable;
        @(posedge clk) disable iff (!reset_n)
        ($rose(recal_ff) && $past(state_ff) == wake_timer_pkg::OSC_RUN) |-> $past(ctrl_ff.slow_osc_cal_enable);
    endproperty
    a_recal_needs_enable: assert property (p_recal_needs_enable) else $error("calibration while disabled");

    property p_prescale_bound;
        @(posedge clk) disable iff (!reset_n)
        (run_tick && !ctrl_wr) |=> (pre_ff <= scale_last(ctrl_ff.wake_tick_scale));
    endproperty
    a_prescale_bound: assert property (p_prescale_bound) else $error("prescaler beyond scale");

    property p_scale_stored;
        @(posedge clk) disable iff (!reset_n)
        ctrl_wr |=> (ctrl_ff.wake_tick_scale == $past(reg_req.wdata[1:0]));
    endproperty
    a_scale_stored: assert property (p_scale_stored) else $error("tick scale not stored");

    property p_wake_period_count_period;
        @(posedge clk) disable iff (!reset_n)
        (fire0 && quiet_ff && $stable(wake_period_count)) |->
            (since_ev0_ff + 32'h0000_0001 == {16'h0, period_eff} * ({17'h0, scale_last(ctrl_ff.wake_tick_scale)} + 32'h0000_0001));
    endproperty
    a_wake_period_count_period: assert property (p_wake_period_count_period) else $error("wake_period_count period wrong");

    property p_settle_interval_select_once;
        @(posedge clk) disable iff (!reset_n)
        fire1 |-> !ev1_seen_ff ##1 (settle_interval_select_pulse && wake_period_count_pulse == 1'b0);
    endproperty
    a_settle_interval_select_once: assert property (p_settle_interval_select_once) else $error("settle_interval_select twice in one cycle");

    property p_reload;
        @(posedge clk) disable iff (!reset_n)
        fire0 |=> (ev0_cnt_ff == `WT_PERIOD_ZERO) && settle_act_ff && wake_period_count_pulse ##1 !wake_period_count_pulse;
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not reload");

endmodule

`default_nettype wire

/* File: verif/wake_on_radio_timer_control_tb.sv */
/*
 * Self-checking bench for the wake-on-radio timer control.
 * Assumes the package and constants header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module wake_on_radio_timer_control_tb;
    // --------------------
    // Signals
    // --------------------
    logic                     clk;            // 100 MHz crystal clock
    logic                     reset_n;        // Async reset, active low
    wake_timer_pkg::reg_req_t req;            // Register strobes
    logic [15:0]              period;         // Wake_period_count count
    logic [7:0]               rdata;          // Read data
    logic                     osc_en;         // Oscillator running
    logic                     cal;            // Calibration running
    logic                     ev0;            // Wake_period_count pulse
    logic                     ev1;            // Settle_interval_select pulse
    int                       n_errors = 0;   // Mismatches
    int                       n_compared = 0; // Comparisons
    int                       cyc = 0;        // Hang counter
    int                       d0;             // Cycles to Wake_period_count
    int                       d1;             // Cycles to Settle_interval_select
    logic                     seen;           // Calibration near Wake_period_count
    localparam int            SLOW = 750;     // Crystal cycles per slow period
    localparam int            LIMIT = 100000; // Run needs about 87k cycles
    int                       settle [8] = '{4, 6, 8, 12, 16, 24, 32, 48};

    wake_on_radio_timer_control i_wake_on_radio_timer_control (
        .clk                 (clk),
        .reset_n             (reset_n),
        .reg_req             (req),
        .wake_period_count   (period),
        .reg_rdata           (rdata),
        .slow_osc_enable     (osc_en),
        .slow_osc_cal_active (cal),
        .wake_period_count_pulse        (ev0),
        .settle_interval_select_pulse        (ev1)
    );

    // --------------------
    // Clock and hang limit
    // --------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A missing pulse would otherwise hang the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            test_done();
        end
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic chk_val(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after an edge; strobe lasts one cycle, then an idle
    // edge so the next call never re-raises it in the same time step
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Data is registered at the taking edge
    task automatic reg_read(input logic [5:0] a, input logic [7:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        chk_val(exp, rdata);
        @(posedge clk);
        #1;
    endtask

    // Counts edges until the chosen pulse shows, bounded
    task automatic wait_ev(input bit which, output int d);
        d = 0;
        do begin
            @(posedge clk);
            #1;
            d++;
        end while ((which ? ev1 : ev0) !== 1'b1 && d < 60000);
    endtask

    // Sync to Wake_period_count, then time Settle_interval_select and the next Wake_period_count
    task automatic measure(input int code, input int per, input int scale);
        wait_ev(1'b0, d0);
        wait_ev(1'b1, d1);
        chk_cnt(settle[code] * SLOW, d1);
        wait_ev(1'b0, d0);
        chk_cnt(per * scale * SLOW, d1 + d0);
        chk_val(8'h00, {7'h00, cal});
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------------------
    // Test sequence
    // --------------------
    initial begin
        reset_n = 1'b0;
        req = '0;
        period = 16'h0002;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        // Reset value, unmapped place, reserved bit
        reg_read(6'h20, 8'hF8);
        reg_read(6'h21, 8'h00);
        reg_write(6'h21, 8'h00);
        reg_write(6'h20, 8'hFF);
        reg_read(6'h20, 8'hFB);
        chk_val(8'h00, {6'h00, osc_en, cal});
        for (int c = 0; c < 4; c++) begin
            reg_write(6'h20, 8'h80 | 8'(c));
            reg_read(6'h20, 8'h80 | 8'(c));
        end
        end_test("registers");
        // Power-up runs calibration before the timer starts
        reg_write(6'h20, 8'h08);
        chk_val(8'h03, {6'h00, osc_en, cal});
        reg_write(6'h20, 8'h08);
        wait_ev(1'b0, d0);
        seen = cal;
        chk_cnt(1, int'(d0 > 4 * SLOW && d0 <= 6 * SLOW + 4));
        @(posedge clk);
        #1;
        chk_val(8'h01, {7'h00, seen | cal});
        end_test("power_up");
        // Settle codes with calibration off, period just above settle
        for (int c = 0; c < 3; c++) begin
            period = 16'(settle[c] + 1);
            reg_write(6'h20, 8'(c << 4));
            measure(c, settle[c] + 1, 1);
        end
        end_test("settle");
        // Scale code 1: one count is 32 slow periods
        period = 16'h0001;
        reg_write(6'h20, 8'h41);
        measure(4, 1, 32);
        end_test("scale");
        // Every slow period, then power down stops all
        reg_write(6'h20, 8'h00);
        wait_ev(1'b0, d0);
        wait_ev(1'b0, d0);
        chk_cnt(SLOW, d0);
        reg_write(6'h20, 8'h80);
        chk_val(8'h00, {6'h00, osc_en, cal});
        d0 = 0;
        repeat (2 * SLOW) begin
            @(posedge clk);
            #1;
            if (ev0 === 1'b1 || ev1 === 1'b1) begin
                d0++;
            end
        end
        chk_cnt(0, d0);
        end_test("power_down");
        test_done();
    end
endmodule

`default_nettype wire
